// ==== include/vih_cfg.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef VIH_CFG_SVH
`define VIH_CFG_SVH

// Register byte offsets on the APB bus
`define VIH_OFF_ENABLE0      8'h00
`define VIH_OFF_PRIORITY0    8'h04
`define VIH_OFF_EXT_ENABLE1  8'h08
`define VIH_OFF_EXT_PRIO1    8'h0C
`define VIH_OFF_TIMER_CTRL   8'h10
`define VIH_OFF_PERIPH_PEND  8'h14
`define VIH_OFF_STATUS       8'h18

// Field positions in enable_reg_0
`define VIH_BIT_GLOBAL_EN    7
`define VIH_BIT_GP_FLAG      6

// Field positions in timer_control_reg
`define VIH_BIT_EXT0_TRIG    0
`define VIH_BIT_EXT0_PEND    1
`define VIH_BIT_EXT1_TRIG    2
`define VIH_BIT_EXT1_PEND    3
`define VIH_BIT_TF0          5
`define VIH_BIT_TF1          7

// Peripheral pending flag layout (one register, several flags for UART0 and for SPI)
`define VIH_PP_UART0_RX      0
`define VIH_PP_UART0_TX      1
`define VIH_PP_TIMER2        2
`define VIH_PP_SPI_LO        3
`define VIH_PP_SPI_HI        6
`define VIH_PP_REST_LO       7
`define VIH_PP_WIDTH         13

// Reset values
`define VIH_RST_ENABLE0      8'h00
`define VIH_RST_PRIO0        6'h00
`define VIH_RST_EXT_EN1      7'h00
`define VIH_RST_EXT_PRIO1    7'h00
`define VIH_RST_PEND         13'h0000

// Sources, vectors and timing
`define VIH_NUM_RANKS        13
`define VIH_VEC_BASE         16'h0003
`define VIH_VEC_RESET        16'h0000
`define VIH_LONG_CALL_CYCLES     4

`endif

// ==== include/vih_pkg.sv ====
// Types shared by the vectored interrupt handler files
package vih_pkg;

  // Vectoring sequencer states
  typedef enum logic [0:0]
  {
    VIH_IDLE = 1'b0,
    VIH_CALL = 1'b1
  } vih_state_e;

  // Fixed-order rank of a source, 0 to 12
  typedef logic [3:0] vih_rank_t;

  // Cycle counter for the long call
  typedef logic [2:0] vih_cnt_t;

endpackage : vih_pkg

// ==== logic/vih_ext_pin.sv ====
// External request pin front end: level or falling-edge pending flag
module vih_ext_pin
  import vih_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  input  wire logic pin_n,
  input  wire logic trigger_edge,
  input  wire logic sw_wr,
  input  wire logic sw_val,
  input  wire logic vector_clr,
  output logic      pending
);

  logic pin_prev_r;
  logic flag_r;
  logic fall;

  // Previous pin level; starts high so reset does not look like an edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_prev_r <= 1'b1;
    else if (clk_en)
      pin_prev_r <= pin_n;
  end

  assign fall = pin_prev_r & ~pin_n;

  // Edge flag: a new edge wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_r <= 1'b0;
    else if (clk_en)
    begin
      if (trigger_edge && fall)
        flag_r <= 1'b1;
      else if (sw_wr)
        flag_r <= sw_val;
      else if (vector_clr)
        flag_r <= 1'b0;
    end
  end

  // Level mode follows the pin, active low, with no latching
  assign pending = trigger_edge ? flag_r : ~pin_n;

endmodule : vih_ext_pin

// ==== logic/vih_handler.sv ====
// Vectored interrupt handler with APB register slave
`include "vih_cfg.svh"

module vih_handler
  import vih_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_request_pin_0_n,
  input  wire logic        ext_request_pin_1_n,
  input  wire logic        timer0_overflow_event,
  input  wire logic        timer1_overflow_event,
  input  wire logic [12:0] periph_flag_set,
  input  wire logic        insn_done,
  input  wire logic        return_from_interrupt_done,
  output logic             irq_request,
  output logic      [15:0] irq_vector,
  output logic             irq_level,
  output logic             long_call_busy,
  output logic             in_service_hi,
  output logic             in_service_lo
);

  // Software-visible configuration and flags
  logic [7:0]  enable_reg_0_r;
  logic [5:0]  priority_reg_0_r;
  logic [6:0]  extended_enable_reg_1_r;
  logic [6:0]  extended_priority_reg_1_r;
  logic        ext0_trigger_select_r;
  logic        ext1_trigger_select_r;
  logic        timer0_overflow_flag_r;
  logic        timer1_overflow_flag_r;
  logic [12:0] periph_pend_r;
  logic        ext0_pending;
  logic        ext1_pending;

  // Arbitration and sequencing
  vih_state_e  state_r;
  vih_cnt_t    call_cnt_r;
  vih_rank_t   rank_r;
  logic        global_irq_enable;
  logic [12:0] src_pend;
  logic [12:0] src_en;
  logic [12:0] src_pri;
  logic [12:0] req_all;
  logic [12:0] req_hi;
  logic [12:0] req_lo;
  logic [4:0]  pick_hi;
  logic [4:0]  pick_lo;
  logic        found;
  logic        found_hi;
  vih_rank_t   win_rank;
  logic        take;

  // APB decode
  logic        acc;
  logic        wr_en;
  logic        hit;
  logic [31:0] rd_data;

  // Lowest set index wins; returns {found, rank}
  function automatic logic [4:0] first_set(input logic [12:0] r);
    logic [4:0] res;
    res = 5'h00;
    for (int i = `VIH_NUM_RANKS - 1; i >= 0; i--)
    begin
      if (r[i])
        res = {1'b1, 4'(i)};
    end
    return res;
  endfunction : first_set

  // Vector address of a rank: base plus eight bytes per step
  function automatic logic [15:0] vector_of(input vih_rank_t rk);
    return `VIH_VEC_BASE + 16'({rk, 3'b000});
  endfunction : vector_of

  // Offset match for a given register
  function automatic logic is_reg(input logic [7:0] a,
                                  input logic [7:0] off);
    return a == off;
  endfunction : is_reg

  // External pin front ends
  vih_ext_pin u_ext0
  (
    .pclk         (pclk),
    .presetn      (presetn),
    .clk_en       (clk_en),
    .pin_n        (ext_request_pin_0_n),
    .trigger_edge (ext0_trigger_select_r),
    .sw_wr        (wr_en && is_reg(paddr, `VIH_OFF_TIMER_CTRL)),
    .sw_val       (pwdata[`VIH_BIT_EXT0_PEND]),
    .vector_clr   (take && rank_r == 4'h0),
    .pending      (ext0_pending)
  );

  vih_ext_pin u_ext1
  (
    .pclk         (pclk),
    .presetn      (presetn),
    .clk_en       (clk_en),
    .pin_n        (ext_request_pin_1_n),
    .trigger_edge (ext1_trigger_select_r),
    .sw_wr        (wr_en && is_reg(paddr, `VIH_OFF_TIMER_CTRL)),
    .sw_val       (pwdata[`VIH_BIT_EXT1_PEND]),
    .vector_clr   (take && rank_r == 4'h2),
    .pending      (ext1_pending)
  );

  // Per-rank pending view; grouped peripheral flags share one vector
  assign src_pend = {periph_pend_r[12:`VIH_PP_REST_LO],
                     |periph_pend_r[`VIH_PP_SPI_HI:`VIH_PP_SPI_LO],
                     periph_pend_r[`VIH_PP_TIMER2],
                     periph_pend_r[`VIH_PP_UART0_TX]
                       | periph_pend_r[`VIH_PP_UART0_RX],
                     timer1_overflow_flag_r,
                     ext1_pending,
                     timer0_overflow_flag_r,
                     ext0_pending};

  // Enable and priority bits per rank
  assign src_en  = {extended_enable_reg_1_r, enable_reg_0_r[5:0]};
  assign src_pri = {extended_priority_reg_1_r, priority_reg_0_r};
  assign global_irq_enable = enable_reg_0_r[`VIH_BIT_GLOBAL_EN];

  // Disabled flags stay pending but never reach the arbiter
  assign req_all = src_pend & src_en & {13{global_irq_enable}};

  // A running high routine blocks all; a low routine blocks low only
  assign req_hi = req_all & src_pri & {13{~in_service_hi}};
  assign req_lo = req_all & ~src_pri
                  & {13{~in_service_hi & ~in_service_lo}};

  // High level first, then fixed rank order inside a level
  assign pick_hi  = first_set(req_hi);
  assign pick_lo  = first_set(req_lo);
  assign found_hi = pick_hi[4];
  assign found    = pick_hi[4] | pick_lo[4];
  assign win_rank = found_hi ? pick_hi[3:0] : pick_lo[3:0];

  // Vector at an instruction boundary; the boundary of a return is skipped
  assign take = clk_en && insn_done && !return_from_interrupt_done && irq_request
                && state_r == VIH_IDLE;

  // Request sampled each idle clock, held low from take to end of call; the one-cycle lag lets a request
  // posted during an enable clear slip in before a single-cycle op
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_request <= 1'b0;
      irq_vector  <= `VIH_VEC_RESET;
      irq_level   <= 1'b0;
      rank_r      <= 4'h0;
    end
    else if (clk_en)
    begin
      if (state_r == VIH_IDLE && !take)
      begin
        irq_request <= found;
        irq_vector  <= vector_of(win_rank);
        irq_level   <= found_hi;
        rank_r      <= win_rank;
      end
      else
        irq_request <= 1'b0;
    end
  end

  // Long call sequencer: four cycles of call after the detect cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r        <= VIH_IDLE;
      call_cnt_r     <= 3'h0;
      long_call_busy <= 1'b0;
    end
    else if (clk_en)
    begin
      case (state_r)
        VIH_IDLE:
        begin
          if (take)
          begin
            state_r        <= VIH_CALL;
            call_cnt_r     <= 3'(`VIH_LONG_CALL_CYCLES - 1);
            long_call_busy <= 1'b1;
          end
        end
        VIH_CALL:
        begin
          if (call_cnt_r == 3'h0)
          begin
            state_r        <= VIH_IDLE;
            long_call_busy <= 1'b0;
          end
          else
            call_cnt_r <= call_cnt_r - 3'h1;
        end
        default:
        begin
          state_r        <= VIH_IDLE;
          long_call_busy <= 1'b0;
        end
      endcase
    end
  end

  // In-service markers; the return ends the highest active level first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in_service_hi <= 1'b0;
      in_service_lo <= 1'b0;
    end
    else if (clk_en)
    begin
      if (take && irq_level)
        in_service_hi <= 1'b1;
      else if (return_from_interrupt_done && in_service_hi)
        in_service_hi <= 1'b0;
      if (take && !irq_level)
        in_service_lo <= 1'b1;
      else if (return_from_interrupt_done && !in_service_hi)
        in_service_lo <= 1'b0;
    end
  end

  // APB access phase: one wait state, write lands at the pready edge
  assign acc   = psel && penable;
  assign wr_en = clk_en && acc && pready && pwrite;
  assign hit   = is_reg(paddr, `VIH_OFF_ENABLE0)
               | is_reg(paddr, `VIH_OFF_PRIORITY0)
               | is_reg(paddr, `VIH_OFF_EXT_ENABLE1)
               | is_reg(paddr, `VIH_OFF_EXT_PRIO1)
               | is_reg(paddr, `VIH_OFF_TIMER_CTRL)
               | is_reg(paddr, `VIH_OFF_PERIPH_PEND)
               | is_reg(paddr, `VIH_OFF_STATUS);

  // Enable and priority registers; all sources low after reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_reg_0_r            <= `VIH_RST_ENABLE0;
      priority_reg_0_r          <= `VIH_RST_PRIO0;
      extended_enable_reg_1_r   <= `VIH_RST_EXT_EN1;
      extended_priority_reg_1_r <= `VIH_RST_EXT_PRIO1;
    end
    else if (wr_en)
    begin
      if (is_reg(paddr, `VIH_OFF_ENABLE0))
        enable_reg_0_r <= pwdata[7:0];
      if (is_reg(paddr, `VIH_OFF_PRIORITY0))
        priority_reg_0_r <= pwdata[5:0];
      if (is_reg(paddr, `VIH_OFF_EXT_ENABLE1))
        extended_enable_reg_1_r <= pwdata[6:0];
      if (is_reg(paddr, `VIH_OFF_EXT_PRIO1))
        extended_priority_reg_1_r <= pwdata[6:0];
    end
  end

  // Trigger selects and timer flags; a hardware set beats any clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext0_trigger_select_r  <= 1'b0;
      ext1_trigger_select_r  <= 1'b0;
      timer0_overflow_flag_r <= 1'b0;
      timer1_overflow_flag_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_en && is_reg(paddr, `VIH_OFF_TIMER_CTRL))
      begin
        ext0_trigger_select_r  <= pwdata[`VIH_BIT_EXT0_TRIG];
        ext1_trigger_select_r  <= pwdata[`VIH_BIT_EXT1_TRIG];
        timer0_overflow_flag_r <= pwdata[`VIH_BIT_TF0]
                                  | timer0_overflow_event;
        timer1_overflow_flag_r <= pwdata[`VIH_BIT_TF1]
                                  | timer1_overflow_event;
      end
      else
      begin
        if (timer0_overflow_event)
          timer0_overflow_flag_r <= 1'b1;
        else if (take && rank_r == 4'h1)
          timer0_overflow_flag_r <= 1'b0;
        if (timer1_overflow_event)
          timer1_overflow_flag_r <= 1'b1;
        else if (take && rank_r == 4'h3)
          timer1_overflow_flag_r <= 1'b0;
      end
    end
  end

  // Peripheral flags are only cleared by software, never on vectoring
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      periph_pend_r <= `VIH_RST_PEND;
    else if (clk_en)
    begin
      if (wr_en && is_reg(paddr, `VIH_OFF_PERIPH_PEND))
        periph_pend_r <= pwdata[12:0] | periph_flag_set;
      else
        periph_pend_r <= periph_pend_r | periph_flag_set;
    end
  end

  // Read mux; reserved bits and unmapped offsets read zero
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (paddr)
      `VIH_OFF_ENABLE0:     rd_data[7:0] = enable_reg_0_r;
      `VIH_OFF_PRIORITY0:   rd_data[5:0] = priority_reg_0_r;
      `VIH_OFF_EXT_ENABLE1: rd_data[6:0] = extended_enable_reg_1_r;
      `VIH_OFF_EXT_PRIO1:   rd_data[6:0] = extended_priority_reg_1_r;
      `VIH_OFF_TIMER_CTRL:
        rd_data[7:0] = {timer1_overflow_flag_r, 1'b0,
                        timer0_overflow_flag_r, 1'b0,
                        ext1_pending, ext1_trigger_select_r,
                        ext0_pending, ext0_trigger_select_r};
      `VIH_OFF_PERIPH_PEND: rd_data[12:0] = periph_pend_r;
      `VIH_OFF_STATUS:
        rd_data[8:0] = {long_call_busy, in_service_lo, in_service_hi,
                        irq_level, irq_request, rank_r};
      default:              rd_data = 32'h0000_0000;
    endcase
  end

  // APB response flops; pready rises one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      pready  <= acc && !pready;
      pslverr <= acc && !pready && !hit;
      if (acc && !pready && !pwrite)
        prdata <= rd_data;
    end
  end

endmodule : vih_handler

// ==== tb/vih_handler_chk.sv ====
// Concurrent checks on the core link of the vectored interrupt handler
module vih_handler_chk
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        insn_done,
  input wire logic        return_from_interrupt_done,
  input wire logic        irq_request,
  input wire logic [15:0] irq_vector,
  input wire logic        irq_level,
  input wire logic        long_call_busy,
  input wire logic        in_service_hi,
  input wire logic        in_service_lo
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic take;
  logic ret;

  // A take needs a finished plain instruction and an idle sequencer
  assign take = clk_en && insn_done && !return_from_interrupt_done && irq_request
                && !long_call_busy;
  assign ret  = clk_en && insn_done && return_from_interrupt_done;

  a_take_busy: assert property (
    take |=> long_call_busy [*4] ##1 !long_call_busy)
    else $error("long call not exactly four cycles");
  a_take_drops: assert property (take |=> !irq_request [*4])
    else $error("request still up during long call");
  a_take_hi: assert property (take && irq_level |=> in_service_hi)
    else $error("high marker not set on take");
  a_take_lo: assert property (take && !irq_level |=> in_service_lo)
    else $error("low marker not set on take");
  a_return_from_interrupt_wait: assert property (
    ret && !long_call_busy |=> !long_call_busy)
    else $error("call started on the return itself");
  a_vec_form: assert property (
    irq_request |-> irq_vector[2:0] == 3'h3 && irq_vector <= 16'h0063)
    else $error("vector outside the table");
  a_hi_block: assert property (
    in_service_hi && $past(in_service_hi)
    && !long_call_busy && !$past(long_call_busy) |-> !irq_request)
    else $error("request raised under high routine");
  a_return_from_interrupt_hi: assert property (ret && in_service_hi |=> !in_service_hi)
    else $error("return left high marker set");

  // Main scenarios reached
  c_take_hi: cover property (take && irq_level);
  c_preempt: cover property (take && in_service_lo && irq_level);
  c_return: cover property (ret && in_service_lo);
endmodule : vih_handler_chk

bind vih_handler vih_handler_chk u_chk
(
  .pclk           (pclk),
  .presetn        (presetn),
  .clk_en         (clk_en),
  .insn_done      (insn_done),
  .return_from_interrupt_done      (return_from_interrupt_done),
  .irq_request    (irq_request),
  .irq_vector     (irq_vector),
  .irq_level      (irq_level),
  .long_call_busy (long_call_busy),
  .in_service_hi  (in_service_hi),
  .in_service_lo  (in_service_lo)
);

// ==== tb/vih_core_model.sv ====
// Behavioural processor core: instruction completions and returns
module vih_core_model
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic [1:0] gap,
  input  wire logic       return_from_interrupt_req,
  input  wire logic       long_call_busy,
  output logic            insn_done,
  output logic            return_from_interrupt_done
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] cnt_r;
  logic       pend_r;

  // One completion every gap+1 cycles; a requested return rides on the next
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt_r     <= 2'h0;
      pend_r    <= 1'b0;
      insn_done <= 1'b0;
      return_from_interrupt_done <= 1'b0;
    end
    else
    begin
      insn_done <= 1'b0;
      return_from_interrupt_done <= 1'b0;
      if (return_from_interrupt_req)
        pend_r <= 1'b1;
      if (!run || long_call_busy) // Nothing retires while the call runs
        cnt_r <= 2'h0;
      else if (cnt_r == gap)
      begin
        cnt_r     <= 2'h0;
        insn_done <= 1'b1;
        return_from_interrupt_done <= pend_r; // Routine closes with a return
        pend_r    <= return_from_interrupt_req;
      end
      else
        cnt_r <= cnt_r + 2'h1;
    end
endmodule : vih_core_model

// ==== tb/vih_handler_tb.sv ====
// Self-checking testbench for the vectored interrupt handler
module vih_handler_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] PSET [13] = '{32'h7, 32'h25, 32'hD, 32'h85,
    32'h2, 32'h4, 32'h20, 32'h80, 32'h100, 32'h200, 32'h400, 32'h800,
    32'h1000};

  logic        pclk, presetn, clk_en, psel, penable, pwrite, rd_e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic        pready, pslverr, pin0_n, pin1_n, tmr0_ev, tmr1_ev;
  logic [12:0] pflag;
  logic [1:0]  gap;
  logic        run, return_from_interrupt_req, insn_done, return_from_interrupt_done, irq_request;
  logic        irq_level, long_call_busy, in_service_hi, in_service_lo;
  logic [15:0] irq_vector;
  int          error_cnt, n_checks;

  // Free-running 250 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  vih_handler dut
  (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_request_pin_0_n(pin0_n), .ext_request_pin_1_n(pin1_n),
    .timer0_overflow_event(tmr0_ev), .timer1_overflow_event(tmr1_ev),
    .periph_flag_set(pflag), .insn_done(insn_done),
    .return_from_interrupt_done(return_from_interrupt_done), .irq_request(irq_request),
    .irq_vector(irq_vector), .irq_level(irq_level),
    .long_call_busy(long_call_busy), .in_service_hi(in_service_hi),
    .in_service_lo(in_service_lo)
  );

  vih_core_model core
  (
    .pclk(pclk), .presetn(presetn), .run(run), .gap(gap),
    .return_from_interrupt_req(return_from_interrupt_req), .long_call_busy(long_call_busy),
    .insn_done(insn_done), .return_from_interrupt_done(return_from_interrupt_done)
  );

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // APB transfer; values read right after an edge are those it sampled
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge pclk);
      n++;
    end
    // Judge by the answer itself, so a late but valid pready still counts
    if (pready !== 1'b1)
    begin
      error_cnt++;
      finish_test();
    end
    rd_q = prdata;
    rd_e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input string what);
    apb(1'b0, a, 32'h0);
    chk(what, rd_q, exp);
  endtask : rd

  // Wait for busy (0), low marker (1) or high marker (2) to reach v
  task automatic wait_for(input int s, input logic v);
    int  n;
    logic x;
    for (n = 0; n < 64; n++)
    begin
      @(posedge pclk);
      x = (s == 0) ? long_call_busy : (s == 1) ? in_service_lo : in_service_hi;
      if (x === v)
        break;
    end
    if (n == 64)
    begin
      error_cnt++;
      finish_test();
    end
  endtask : wait_for

  // Ask the core to end the current routine
  task automatic return_from_interrupt();
    return_from_interrupt_req <= 1'b1;
    @(posedge pclk);
    return_from_interrupt_req <= 1'b0;
  endtask : return_from_interrupt

  // Hang guard
  initial
  begin
    #200000;
    error_cnt++;
    finish_test();
  end

  initial
  begin
    int eb;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {tmr0_ev, tmr1_ev, pflag, run, return_from_interrupt_req} = '0;
    {clk_en, pin0_n, pin1_n, gap} = 5'h1F;
    error_cnt = 0;
    n_checks = 0;
    cyc(2);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++)
      rd(8'(i * 4), 32'h0, "reset value");
    rd(8'h1C, 32'h0, "unmapped read");
    chk("unmapped error", 32'(rd_e), 32'h1);
    // Every rank by software event, odd ranks at high level
    for (int r = 0; r < 13; r++)
    begin
      eb = (r < 6) ? r : r - 6;
      wr(8'h00, 32'h80 | ((r < 6) ? (32'h1 << r) : 32'h0));
      wr(8'h08, (r < 6) ? 32'h0 : (32'h1 << eb));
      wr((r < 6) ? 8'h04 : 8'h0C, (r % 2) ? (32'h1 << eb) : 32'h0);
      wr((r < 4) ? 8'h10 : 8'h14, PSET[r]);
      cyc(2);
      chk("request", 32'(irq_request), 32'h1);
      chk("vector", 32'(irq_vector), 32'h3 + 8 * r);
      chk("level", 32'(irq_level), 32'(r % 2));
      wr(8'h10, 32'h0);
      wr(8'h14, 32'h0);
      wr(8'h04, 32'h0);
      wr(8'h0C, 32'h0);
    end
    wr(8'h08, 32'h0);
    // Disabled flag is kept but ignored; global gate
    wr(8'h00, 32'h0); // Core stopped, nothing slips past the clear
    tmr0_ev <= 1'b1;
    cyc(1);
    tmr0_ev <= 1'b0;
    rd(8'h10, 32'h20, "timer0 flag");
    chk("masked request", 32'(irq_request), 32'h0);
    wr(8'h00, 32'h02);
    cyc(2);
    chk("global off", 32'(irq_request), 32'h0);
    wr(8'h00, 32'h82);
    cyc(2);
    chk("timer0 vector", 32'(irq_vector), 32'h000B);
    run <= 1'b1;
    wait_for(0, 1'b1);
    chk("low marker", 32'(in_service_lo), 32'h1);
    rd(8'h10, 32'h0, "timer0 cleared");
    // High preempts low, then blocks another high
    wr(8'h0C, 32'h1);
    wr(8'h08, 32'h1);
    wr(8'h14, 32'h8);
    wait_for(2, 1'b1);
    chk("preempt vector", 32'(irq_vector), 32'h0033);
    wr(8'h04, 32'h08);
    wr(8'h00, 32'h8A);
    tmr1_ev <= 1'b1;
    cyc(1);
    tmr1_ev <= 1'b0;
    cyc(6);
    chk("high blocks high", 32'(irq_request), 32'h0);
    return_from_interrupt();
    wait_for(2, 1'b0);
    wait_for(0, 1'b1);
    chk("rank order", 32'(irq_vector), 32'h001B);
    return_from_interrupt();
    wait_for(2, 1'b0);
    wait_for(0, 1'b1);
    chk("re-entry vector", 32'(irq_vector), 32'h0033);
    wr(8'h14, 32'h0); // Routine clears its own flag before return
    return_from_interrupt();
    wait_for(2, 1'b0);
    return_from_interrupt();
    wait_for(1, 1'b0);
    // External pins, level then falling edge, prompt core
    run <= 1'b0;
    gap <= 2'h0;
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h81);
    pin0_n <= 1'b0;
    pin1_n <= 1'b0;
    cyc(3);
    rd(8'h10, 32'hA, "level pins");
    pin0_n <= 1'b1; // Released before any routine could end
    pin1_n <= 1'b1;
    cyc(3);
    rd(8'h10, 32'h0, "level released");
    wr(8'h10, 32'h1);
    pin0_n <= 1'b0;
    cyc(2);
    pin0_n <= 1'b1;
    cyc(2);
    rd(8'h10, 32'h3, "edge latched");
    run <= 1'b1;
    wait_for(0, 1'b1);
    chk("ext0 vector", 32'(irq_vector), 32'h0003);
    rd(8'h10, 32'h1, "edge cleared");
    return_from_interrupt();
    wait_for(1, 1'b0);
    // One of several flags of a source
    run <= 1'b0;
    wr(8'h08, 32'h1);
    pflag <= 13'h0010;
    cyc(1);
    pflag <= 13'h0000;
    cyc(2);
    rd(8'h14, 32'h10, "spi flag");
    chk("spi vector", 32'(irq_vector), 32'h0033);
    // Clock enable low freezes state: an overflow pulse then is lost
    clk_en  <= 1'b0;
    tmr0_ev <= 1'b1;
    cyc(1);
    tmr0_ev <= 1'b0;
    clk_en  <= 1'b1;
    rd(8'h10, 32'h1, "frozen flag");
    chk("frozen request", 32'(irq_request), 32'h1);
    finish_test();
  end
endmodule : vih_handler_tb
